// file: logic/tws_pkg.sv
// package for the three-wire serial shifter: register map, fields, counts
// assumes a 32-bit classic wishbone slave port and a 20 MHz system clock
package tws_pkg;
    // register byte addresses (index times four)
    localparam logic [7:0] ADDR_PINS    = 8'h28; // index 0ah
    localparam logic [7:0] ADDR_START   = 8'h68; // index 1ah
    localparam logic [7:0] ADDR_MODE    = 8'h00;
    localparam logic [7:0] ADDR_SHIFT   = 8'h04;
    localparam logic [7:0] ADDR_PORTD   = 8'h08;
    localparam logic [7:0] ADDR_PORTDIR = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_MASK    = 8'h14;
    // field positions
    localparam int PINS_EN_BIT    = 0;
    localparam int START_BIT      = 3;
    localparam int MODE_SEL_LO    = 0;
    localparam int MODE_SEL_HI    = 1;
    localparam int MODE_FLOAT_BIT = 2;
    localparam int STAT_DONE_BIT  = 0;
    // clock selector codes, divide ratios and half period terminal counts (half period minus one) in system clocks
    localparam logic [1:0] SEL_EXT  = 2'h0;
    localparam logic [1:0] SEL_D16  = 2'h1;
    localparam logic [1:0] SEL_D128 = 2'h2;
    localparam int DIV16   = 16;
    localparam int DIV128  = 128;
    localparam int DIV1024 = 1024;
    localparam logic [9:0] HALF16   = 10'(DIV16 / 2 - 1);
    localparam logic [9:0] HALF128  = 10'(DIV128 / 2 - 1);
    localparam logic [9:0] HALF1024 = 10'(DIV1024 / 2 - 1);
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [3:0] PORT_RST  = 4'h0;

    typedef struct packed {
        logic       pins_en;
        logic       out_float;
        logic [1:0] clk_sel;
    } tws_mode_t;

    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] out;
    } tws_pins_t;
endpackage

// file: logic/tws_clkgen.sv
// internal serial clock generator: divides the system clock, idles high
// assumes clk_en_i gates all state; run_i low forces the clock high
`timescale 1ns/1ns
`default_nettype none
module tws_clkgen (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clk_en_i,
    // control
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    // serial clock and its edges
    output logic            sck_o,
    output logic            fall_o,
    output logic            rise_o
);
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic       sck_reg;
    logic       sck_next;
    logic [9:0] half;

    always_comb begin
        case (sel_i)
            tws_pkg::SEL_D16:  half = tws_pkg::HALF16;
            tws_pkg::SEL_D128: half = tws_pkg::HALF128;
            default:           half = tws_pkg::HALF1024;
        endcase
        cnt_next = cnt_reg;
        sck_next = sck_reg;
        fall_o   = 1'b0;
        rise_o   = 1'b0;
        // idle high so each transfer opens with a falling edge
        if (!run_i) begin
            cnt_next = 10'h000;
            sck_next = 1'b1;
        end else if (cnt_reg == half) begin
            cnt_next = 10'h000;
            sck_next = ~sck_reg;
            fall_o   = sck_reg;
            rise_o   = ~sck_reg;
        end else begin
            cnt_next = cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 10'h000;
            sck_reg <= 1'b1;
        end else if (clk_en_i) begin
            cnt_reg <= cnt_next;
            sck_reg <= sck_next;
        end
    end

    assign sck_o = sck_reg;
endmodule
`default_nettype wire

// file: logic/tws_top.sv
// three-wire serial shifter with port d pins and wishbone register access
// assumes pins are synchronous to clk_i; pads resolve open drain from oe
// Notes on behaviour
// - eight-bit shift register, mode register and bit counter; eight bits each transfer
// - selector 00 external clock; 01,10,11 system clock over 16,128,1024
// - an internal serial clock is driven out on the clock pin
// - pin enable hands port d bits 0,1,2 to clock, output, input
// - writing start flag begins transfer on falling edges, clears done request
// - msb presented on output at each falling edge; never lsb first
// - input pin sampled at each rising serial clock edge
// - each clock shifts by one, input bit enters the lsb
// - counter ends transfer after eight clocks: start cleared, done set
// - port d bit 1 output latch is the shift register output latch
// - input captured on every rising clock only while start flag set and serial function selected
// - float 0 full duplex; float 1 receive only; enable 0 plain port
// - start flag low: no shifting, shift register acts as plain register
// - pin enable is bit 0 at 0ah, start flag bit 3 at 1ah
// - port read: clock latch if internal, pin if external; input pin level
`timescale 1ns/1ns
`default_nettype none
module tws_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             int_o,
    // port d pins, open drain
    input  wire logic [3:0]  pd_i,
    output logic      [3:0]  pd_o,
    output logic      [3:0]  pd_oe_o
);
    tws_pkg::tws_mode_t mode_reg, mode_next;
    tws_pkg::tws_pins_t pins_reg, pins_next;
    logic [7:0]  shift_reg, shift_next;
    logic [3:0]  latch_reg, latch_next;
    logic [3:0]  dir_reg, dir_next;
    logic [3:0]  bits_reg, bits_next;
    logic        start_reg, start_next;
    logic        done_reg, done_next;
    logic        mask_reg, mask_next;
    logic        ack_reg, ack_next;
    logic        int_reg, int_next;
    logic        sin_reg, sin_next;
    logic        ext_sck_reg, ext_sck_next;
    logic [31:0] rd_reg, rd_next;
    logic        int_sck, int_fall, int_rise;
    logic        internal, sfall, srise, wr, rd, run;

    function automatic logic hit(input logic [7:0] a);
        hit = (adr_i == a);
    endfunction

    assign internal = (mode_reg.clk_sel != tws_pkg::SEL_EXT);
    assign run      = start_reg & internal & mode_reg.pins_en;

    tws_clkgen u_clkgen (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clk_en_i (clk_en_i),
        .run_i    (run),
        .sel_i    (mode_reg.clk_sel),
        .sck_o    (int_sck),
        .fall_o   (int_fall),
        .rise_o   (int_rise)
    );

    // external edges from the clock pin
    assign sfall = internal ? int_fall : (ext_sck_reg & ~pd_i[0]);
    assign srise = internal ? int_rise : (~ext_sck_reg & pd_i[0]);
    assign wr = cyc_i & stb_i & we_i & ~ack_reg & sel_i[0];
    assign rd = cyc_i & stb_i & ~ack_reg;

    always_comb begin
        mode_next    = mode_reg;
        shift_next   = shift_reg;
        latch_next   = latch_reg;
        dir_next     = dir_reg;
        bits_next    = bits_reg;
        start_next   = start_reg;
        done_next    = done_reg;
        mask_next    = mask_reg;
        sin_next     = sin_reg;
        ext_sck_next = pd_i[0];
        ack_next     = cyc_i & stb_i & ~ack_reg;
        rd_next      = 32'h0000_0000;
        if (wr) begin
            // pin enable and start flag locations
            if (hit(tws_pkg::ADDR_PINS)) begin
                mode_next.pins_en = dat_i[tws_pkg::PINS_EN_BIT];
            end
            if (hit(tws_pkg::ADDR_MODE)) begin
                mode_next.clk_sel   = dat_i[tws_pkg::MODE_SEL_HI:tws_pkg::MODE_SEL_LO];
                mode_next.out_float = dat_i[tws_pkg::MODE_FLOAT_BIT];
            end
            // idle shifter is a plain register
            if (hit(tws_pkg::ADDR_SHIFT)) begin
                shift_next = dat_i[7:0];
            end
            // bit 1 latch shares the shifter output latch
            if (hit(tws_pkg::ADDR_PORTD)) begin
                latch_next = dat_i[3:0];
            end
            if (hit(tws_pkg::ADDR_PORTDIR)) begin
                dir_next = dat_i[3:0];
            end
            if (hit(tws_pkg::ADDR_MASK)) begin
                mask_next = dat_i[tws_pkg::STAT_DONE_BIT];
            end
            if (hit(tws_pkg::ADDR_STATUS) && dat_i[tws_pkg::STAT_DONE_BIT]) begin
                done_next = 1'b0;
            end
            if (hit(tws_pkg::ADDR_START) && dat_i[tws_pkg::START_BIT]) begin
                start_next = 1'b1;
                bits_next  = 4'h0;
                done_next  = 1'b0;
            end
        end
        if (start_reg && mode_reg.pins_en) begin
            // msb onto the output latch at falling edge
            if (sfall) begin
                latch_next[1] = shift_reg[7];
            end
            if (srise) begin
                sin_next   = pd_i[2];
                shift_next = {shift_reg[6:0], pd_i[2]};
                bits_next  = bits_reg + 4'h1;
                if (bits_reg == tws_pkg::BITS_PER_XFER - 4'h1) begin
                    start_next = 1'b0;
                    done_next  = 1'b1;
                end
            end
        end
        if (rd) begin
            case (adr_i)
                tws_pkg::ADDR_PINS:    rd_next[0] = mode_reg.pins_en;
                tws_pkg::ADDR_START:   rd_next[tws_pkg::START_BIT] = start_reg;
                tws_pkg::ADDR_MODE:    rd_next[2:0] = {mode_reg.out_float, mode_reg.clk_sel};
                tws_pkg::ADDR_SHIFT:   rd_next[7:0] = shift_reg;
                tws_pkg::ADDR_PORTD: begin
                    rd_next[3:0] = dir_reg & latch_reg | ~dir_reg & pd_i;
                    if (mode_reg.pins_en) begin
                        rd_next[0] = internal ? latch_reg[0] : pd_i[0];
                        rd_next[2] = pd_i[2];
                    end
                end
                tws_pkg::ADDR_PORTDIR: rd_next[3:0] = dir_reg;
                tws_pkg::ADDR_STATUS:  rd_next[0] = done_reg;
                tws_pkg::ADDR_MASK:    rd_next[0] = mask_reg;
                default:               rd_next = 32'h0000_0000;
            endcase
        end
        int_next = done_next & mask_next;
    end

    // pin drive: open drain, oe high pulls low
    always_comb begin
        pins_next.out = 4'h0;
        pins_next.oe  = dir_reg & ~latch_reg;
        if (mode_reg.pins_en) begin
            pins_next.oe[0] = internal & ~int_sck;
            pins_next.oe[1] = ~mode_reg.out_float & ~latch_next[1];
            pins_next.oe[2] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg    <= '0;
            pins_reg    <= '0;
            shift_reg   <= tws_pkg::SHIFT_RST;
            latch_reg   <= tws_pkg::PORT_RST;
            dir_reg     <= tws_pkg::PORT_RST;
            bits_reg    <= 4'h0;
            start_reg   <= 1'b0;
            done_reg    <= 1'b0;
            mask_reg    <= 1'b0;
            ack_reg     <= 1'b0;
            int_reg     <= 1'b0;
            sin_reg     <= 1'b0;
            ext_sck_reg <= 1'b1;
            rd_reg      <= 32'h0000_0000;
        end else if (clk_en_i) begin
            mode_reg    <= mode_next;
            pins_reg    <= pins_next;
            shift_reg   <= shift_next;
            latch_reg   <= latch_next;
            dir_reg     <= dir_next;
            bits_reg    <= bits_next;
            start_reg   <= start_next;
            done_reg    <= done_next;
            mask_reg    <= mask_next;
            ack_reg     <= ack_next;
            int_reg     <= int_next;
            sin_reg     <= sin_next;
            ext_sck_reg <= ext_sck_next;
            rd_reg      <= rd_next;
        end
    end

    assign dat_o   = rd_reg;
    assign ack_o   = ack_reg;
    assign int_o   = int_reg;
    assign pd_o    = pins_reg.out;
    assign pd_oe_o = pins_reg.oe;

    a_done_after_eight: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_en_i && start_reg && mode_reg.pins_en && srise && bits_reg == 4'h7
        |=> done_reg && !start_reg)
        else $error("transfer did not finish after eight clocks");

    a_start_clears_done: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_en_i && wr && hit(tws_pkg::ADDR_START) && dat_i[3] && !start_reg
        |=> start_reg && !done_reg)
        else $error("start did not clear done request");

    a_shift_lsb_in: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_en_i && start_reg && mode_reg.pins_en && srise && !wr
        |=> shift_reg[0] == $past(pd_i[2]) && shift_reg[7:1] == $past(shift_reg[6:0]))
        else $error("shift did not take input into lsb");

    a_msb_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_en_i && start_reg && mode_reg.pins_en && sfall
        |=> latch_reg[1] == $past(shift_reg[7]))
        else $error("msb not presented on falling edge");

    a_idle_no_shift: assert property (@(posedge clk_i) disable iff (rst_i)
        !start_reg && !wr |=> $stable(shift_reg))
        else $error("shifter moved while stopped");

    a_clock_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !start_reg ##1 !start_reg ##1 !start_reg |-> int_sck)
        else $error("internal clock not idle high");

    a_float_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg.pins_en && mode_reg.out_float ##1 clk_en_i |-> !pd_oe_o[1])
        else $error("output driven in receive only mode");

    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_en_i |=> int_o == (done_reg & mask_reg))
        else $error("interrupt does not follow status and mask");
endmodule
`default_nettype wire

// file: tb/tws_periph.sv
// behavioural serial peripheral on the far side of the three-wire shifter
// assumes open-drain pins with pull-ups; levels are sampled on the system clock
`timescale 1ns/1ns
`default_nettype none
module tws_periph #(
    parameter int HALF = 20
) (
    // system clock and control from the bench
    input  wire logic       clk_i,
    input  wire logic       load_i,
    input  wire logic [7:0] tx_i,
    input  wire logic       ext_go_i,
    // wire levels
    input  wire logic       sck_i,
    input  wire logic       so_i,
    // open-drain drives, 1 = released, and the received byte
    output logic            si_o,
    output logic            sck_o,
    output logic [7:0]      rx_o
);
    logic       sck_q;
    logic [7:0] tx;
    int         rises;
    int         edges;
    int         half_cnt;

    always_ff @(posedge clk_i) begin
        sck_q <= sck_i;
        if (load_i) begin
            tx    <= tx_i;
            si_o  <= 1'b1;
            sck_o <= 1'b1;
            rx_o  <= 8'h00;
            rises <= 0;
            edges <= 0;
        end else begin
            if (sck_q && !sck_i && rises < 8) begin
                si_o <= tx[7];
                tx   <= {tx[6:0], 1'b0};
            end
            if (!sck_q && sck_i) begin
                rx_o  <= {rx_o[6:0], so_i};
                rises <= rises + 1;
            end
            // hold time over: line goes back to its pull-up
            if (!sck_q && sck_i && rises == 7) begin
                si_o <= 1'b1;
            end
            if (ext_go_i && edges == 0) begin
                edges    <= 16;
                half_cnt <= HALF;
            end else if (edges != 0 && half_cnt == 0) begin
                sck_o    <= ~sck_o;
                edges    <= edges - 1;
                half_cnt <= HALF;
            end else if (edges != 0) begin
                half_cnt <= half_cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/three_wire_serial_shifter_test.sv
// self-checking bench: wishbone register access and transfers in every clock mode
// assumes the peripheral model drives the far side of the open-drain port d pins
`timescale 1ns/1ns
`default_nettype none
module three_wire_serial_shifter_test;
    logic        clk_i, rst_i, cyc, stb, we, ack_o, int_o, load, ext_go;
    logic [7:0]  adr, ptx, prx;
    logic [3:0]  sel, pd_o, pd_oe_o, pd_i;
    logic [31:0] dat, dat_o, q;
    logic        p_si, p_sck, sck_w, so_w, si_w, sck_d;
    int          num_errors, num_checks, falls, seed, falls_at_start;
    logic [7:0]  regs [6];

    // open-drain resolution with pull-ups
    assign sck_w = ~pd_oe_o[0] & p_sck;
    assign so_w  = ~pd_oe_o[1];
    assign si_w  = ~pd_oe_o[2] & p_si;
    assign pd_i  = {~pd_oe_o[3], si_w, so_w, sck_w};

    tws_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .int_o(int_o), .pd_i(pd_i), .pd_o(pd_o), .pd_oe_o(pd_oe_o));
    tws_periph u_peer (.clk_i(clk_i), .load_i(load), .tx_i(ptx), .ext_go_i(ext_go),
        .sck_i(sck_w), .so_i(so_w), .si_o(p_si), .sck_o(p_sck), .rx_o(prx));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        sck_d <= sck_w;
        if (sck_d === 1'b1 && sck_w === 1'b0) falls <= falls + 1;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; ack and read data taken at the same edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic xfer(input logic [1:0] csel, input logic flt, input logic msk);
        logic [7:0] tx, pr;
        int         n;
        tx = 8'($random(seed));
        pr = 8'($random(seed));
        @(posedge clk_i);
        load <= 1'b1; ptx <= pr;
        @(posedge clk_i);
        load <= 1'b0;
        wb(1'b1, tws_pkg::ADDR_MODE, {29'h0, flt, csel});
        wb(1'b1, tws_pkg::ADDR_MASK, {31'h0, msk});
        wb(1'b1, tws_pkg::ADDR_SHIFT, {24'h0, tx});
        chk(32'(sck_w), 32'h1);
        // falls has one driver; measure from a snapshot instead of clearing it
        falls_at_start = falls;
        wb(1'b1, tws_pkg::ADDR_START, 32'h08);
        wb(1'b0, tws_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        if (csel == tws_pkg::SEL_EXT) begin
            @(posedge clk_i) ext_go <= 1'b1;
            @(posedge clk_i) ext_go <= 1'b0;
        end
        n = 0;
        do begin
            wb(1'b0, tws_pkg::ADDR_START, 32'h0);
            n++;
        end while (q[tws_pkg::START_BIT] !== 1'b0 && n < 4000);
        if (n >= 4000) begin
            num_errors++;
            final_report();
        end
        repeat (4) @(posedge clk_i);
        chk(32'(falls - falls_at_start), 32'h8);
        chk(32'(prx), flt ? 32'hff : {24'h0, tx});
        wb(1'b0, tws_pkg::ADDR_SHIFT, 32'h0);
        chk(q, {24'h0, pr});
        wb(1'b0, tws_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h1);
        chk(32'(int_o), 32'(msk));
    endtask

    initial begin
        seed = 27754;
        num_errors = 0; num_checks = 0; falls_at_start = 0;
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        sel = 4'h0; dat = 32'h0; load = 1'b1; ext_go = 1'b0; ptx = 8'hff;
        regs = '{tws_pkg::ADDR_MODE, tws_pkg::ADDR_SHIFT, tws_pkg::ADDR_STATUS,
                 tws_pkg::ADDR_MASK, tws_pkg::ADDR_PINS, 8'h40};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0; load <= 1'b0;
        foreach (regs[i]) begin
            wb(1'b0, regs[i], 32'h0);
            chk(q, 32'h0);
        end
        // plain register while stopped
        wb(1'b1, tws_pkg::ADDR_SHIFT, 32'ha5);
        repeat (40) @(posedge clk_i);
        wb(1'b0, tws_pkg::ADDR_SHIFT, 32'h0);
        chk(q, 32'ha5);
        wb(1'b1, tws_pkg::ADDR_PINS, 32'h1);
        for (int s = 0; s < 4; s++) xfer(2'(s), 1'b0, 1'b1);
        wb(1'b1, tws_pkg::ADDR_STATUS, 32'h1);
        wb(1'b0, tws_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        chk(32'(int_o), 32'h0);
        xfer(tws_pkg::SEL_D16, 1'b1, 1'b0);
        repeat (3) xfer(2'($random(seed)), 1'($random(seed)), 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
